// >>> common/dswbm_pkg.sv
/*
  dswbm_pkg: types shared by the mapper files.
  Assumes: dswbm_regs.svh is reachable on the include path.
*/
`include "dswbm_regs.svh"
package dswbm_pkg;

  // ****************************************************************
  // one-hot route of a data space access
  // ****************************************************************
  typedef enum logic [5:0] {
    RT_NONE   = 6'h01,
    RT_WINDOW = 6'h02,
    RT_PRAM   = 6'h04,
    RT_NVM    = 6'h08,
    RT_GRAM   = 6'h10,
    RT_OTHER  = 6'h20
  } dswbm_route_type;

  // ****************************************************************
  // one-hot access sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MEM  = 4'h2,
    ST_ROM  = 4'h4,
    ST_ROMW = 4'h8
  } dswbm_state_type;

  // core data space request, valid while rd or wr is high
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       bitop;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dswbm_req_type;

  // core program flow controls, one-cycle pulses
  typedef struct packed {
    logic                    nmi;
    logic                    irq;
    logic [1:0]              irq_sel;
    logic                    ret;
    logic                    call;
    logic                    jump;
    logic                    inc;
    logic [`DSWBM_PC_W-1:0]  target;
  } dswbm_flow_type;

endpackage

// >>> common/dswbm_regs.svh
/*
  dswbm_regs.svh: addresses, field positions, vectors and sizes of the
  data space window and page mapper.
  Assumes: included by bare name; definitions only.
*/
`ifndef DSWBM_REGS_SVH
`define DSWBM_REGS_SVH

// ****************************************************************
// register addresses in data space
// ****************************************************************
`define DSWBM_WIN_BASE_ADDR 8'hC9
`define DSWBM_PAGE_SEL_ADDR 8'hE8

// ****************************************************************
// data space regions
// ****************************************************************
`define DSWBM_PAGE_HI       8'h3F
`define DSWBM_WIN_LO        8'h40
`define DSWBM_WIN_HI        8'h7F
`define DSWBM_GRAM_LO       8'h84
`define DSWBM_GRAM_HI       8'hBF
`define DSWBM_GRAM_BYTES    60
`define DSWBM_PAGE_BYTES    64
`define DSWBM_WIN_BITS      6

// ****************************************************************
// page select fields, reset values, vectors, widths
// ****************************************************************
`define DSWBM_SEL_RAM2      4
`define DSWBM_SEL_RAM1      3
`define DSWBM_SEL_NVM1      1
`define DSWBM_SEL_NVM0      0
`define DSWBM_SEL_USED      5'h1B
`define DSWBM_SEL_SMALL     5'h01
`define DSWBM_PC_W          12
`define DSWBM_STACK_DEPTH   6
`define DSWBM_PROG_AW       13
`define DSWBM_PROG_TOP      13'h1FFF
`define DSWBM_PROG_LAST     13'h0FFF
`define DSWBM_IRQ_VEC_BASE  12'hFF0
`define DSWBM_NMI_VEC       12'hFFC
`define DSWBM_RESET_VEC     12'hFFE
`define DSWBM_FILL          8'hFF
`define DSWBM_PC_RESET      12'h000

`endif

// >>> testbench/dswbm_mapper_chk.sv
/* dswbm_mapper_chk: port timing checks of the mapper.
   Assumes: bound into dswbm_mapper, one clock, sync reset. */
module dswbm_mapper_chk
  import dswbm_pkg::*;
(
  input wire logic           clk_in,
  input wire logic           reset_in,
  input wire dswbm_req_type  core_req_in,
  input wire logic           core_ready_out,
  input wire logic           core_ack_out,
  input wire dswbm_flow_type flow_in,
  input wire logic [11:0]    pc_out,
  input wire logic           prog_rd_out,
  input wire logic [12:0]    prog_addr_out,
  input wire logic           nvm_rd_out,
  input wire logic [5:0]     nvm_addr_out,
  input wire logic           protect_in,
  input wire logic           ext_ack_out,
  input wire logic [7:0]     ext_data_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // accepted request, and the slower window read among them
  wire take = core_ready_out && (core_req_in.rd || core_req_in.wr);
  wire win  = take && core_req_in.rd && (core_req_in.addr[7:6] == 2'b01);
  // answer latency per region
  ack_time_a: assert property (take && !win |-> ##2 core_ack_out)
    else $error("core ack late");
  win_ack_a: assert property (win |=> !core_ack_out ##1 !core_ack_out ##1 core_ack_out)
    else $error("window ack late");
  win_addr_a: assert property (win |=> prog_rd_out && !prog_addr_out[12] &&
    prog_addr_out[5:0] == $past(core_req_in.addr[5:0])) else $error("window address");
  page_addr_a: assert property (nvm_rd_out |-> nvm_addr_out == $past(core_req_in.addr[5:0]))
    else $error("page offset");
  // program flow vectors and return stack
  pc_reset_a: assert property ($fell(reset_in) |-> pc_out == 12'hFFE)
    else $error("reset vector");
  nmi_vec_a: assert property (flow_in.nmi |=> pc_out == 12'hFFC)
    else $error("nmi vector");
  irq_vec_a: assert property (flow_in.irq && !flow_in.nmi |=>
    pc_out == 12'hFF0 + {$past(flow_in.irq_sel), 1'b0}) else $error("irq vector");
  call_ret_a: assert property (flow_in.call && !flow_in.irq && !flow_in.nmi ##1
    flow_in.ret && !flow_in.irq && !flow_in.nmi |=> pc_out == $past(pc_out, 2))
    else $error("return address");
  // protected readout never leaks memory
  protect_data_a: assert property (ext_ack_out && protect_in && $past(protect_in) &&
    $past(protect_in, 2) |-> ext_data_out == 8'hFF) else $error("readout leak");
endmodule

bind dswbm_mapper dswbm_mapper_chk chk (.clk_in, .reset_in, .core_req_in, .core_ready_out,
  .core_ack_out, .flow_in, .pc_out, .prog_rd_out, .prog_addr_out, .nvm_rd_out,
  .nvm_addr_out, .protect_in, .ext_ack_out, .ext_data_out);

// >>> testbench/dswbm_mapper_test.sv
/* dswbm_mapper_test: self-checking bench of the data space mapper.
   Assumes: large variant defaults, memory model on the far side. */
module dswbm_mapper_test;
  import dswbm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, reset_in = 1'b1, ext_rd_in = 1'b0, protect_in = 1'b0;
  logic [12:0] ext_addr_in = 13'h0000, prog_addr_out;
  dswbm_req_type core_req_in = '0;
  dswbm_flow_type flow_in = '0;
  logic core_ready_out, core_ack_out, prog_rd_out, nvm_rd_out, nvm_page_out, oth_rd_out;
  logic ext_ack_out, page_conflict_out;
  logic [11:0] pc_out;
  logic [5:0] nvm_addr_out;
  logic [7:0] core_rdata_out, prog_data_in, nvm_rdata_in, oth_addr_out, oth_rdata_in;
  logic [7:0] ext_data_out;
  int bad_count = 0, num_checks = 0;
  dswbm_mapper uut (.clk_in, .reset_in, .core_req_in, .core_ready_out, .core_ack_out,
    .core_rdata_out, .flow_in, .pc_out, .prog_rd_out, .prog_addr_out, .prog_data_in,
    .nvm_rd_out, .nvm_wr_out(), .nvm_page_out, .nvm_addr_out, .nvm_wdata_out(),
    .nvm_rdata_in, .oth_rd_out, .oth_wr_out(), .oth_addr_out, .oth_wdata_out(),
    .oth_rdata_in, .ext_rd_in, .ext_addr_in, .protect_in, .ext_ack_out, .ext_data_out,
    .page_conflict_out);
  dswbm_mem_model mdl (.clk_in, .prog_rd_in(prog_rd_out), .prog_addr_in(prog_addr_out),
    .prog_data_out(prog_data_in), .nvm_rd_in(nvm_rd_out), .nvm_page_in(nvm_page_out),
    .nvm_addr_in(nvm_addr_out), .nvm_rdata_out(nvm_rdata_in), .oth_rd_in(oth_rd_out),
    .oth_addr_in(oth_addr_out), .oth_rdata_out(oth_rdata_in));
  // 125 MHz clock
  always #4 clk_in = ~clk_in;
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(string w, logic [11:0] seen, logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", w, exp, seen);
    end
  endtask
  function automatic logic [7:0] pf(logic [12:0] a);
    return a[7:0] ^ {3'b000, a[12:8]};
  endfunction
  // one core access, held a cycle, then bounded wait for ack
  task automatic acc(logic w, logic bo, logic [7:0] a, logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    core_req_in = '{rd: !w, wr: w, bitop: bo, addr: a, wdata: d};
    @(negedge clk_in);
    {core_req_in.rd, core_req_in.wr} = 2'b00;
    while (core_ack_out !== 1'b1 && n < 8) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 8) bad_count++;
    q = core_rdata_out;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic bo = 1'b0);
    logic [7:0] q;
    acc(1'b1, bo, a, d, q);
  endtask
  task automatic rd(string w, logic [7:0] a, logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, 1'b0, a, 8'h00, q);
    check(w, {4'h0, q}, {4'h0, e});
  endtask
  task automatic flow(dswbm_flow_type f, logic [11:0] e);
    flow_in = f;
    @(negedge clk_in);
    check("pc", pc_out, e);
  endtask
  // pin held until the ack, then low for the sync edge
  task automatic ext(logic [12:0] a, logic p, logic [7:0] e);
    int n;
    n = 0;
    protect_in = p;
    ext_addr_in = a;
    ext_rd_in = 1'b1;
    while (ext_ack_out !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    ext_rd_in = 1'b0;
    if (n == 20) bad_count++;
    check("ext", {4'h0, ext_data_out}, {4'h0, e});
    repeat (4) @(negedge clk_in);
  endtask
  task automatic test_done();
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_window();
    wr(8'hC9, 8'h28);
    rd("win", 8'h59, pf(13'h0A19));
    wr(8'hC9, 8'h29);
    rd("win step", 8'h59, pf(13'h0A59));
    wr(8'hC9, 8'h00, 1'b1);
    rd("win bitop", 8'h40, pf(13'h0A40));
    rd("win rd", 8'hC9, 8'hFF);
    wr(8'hC9, 8'hFF);
    rd("win top", 8'h7F, pf(13'h0FFF));
  endtask
  task automatic t_pages();
    wr(8'hE8, 8'h01);
    rd("nvm0", 8'h05, 8'h85);
    wr(8'hE8, 8'h02);
    rd("nvm1", 8'h05, 8'hC5);
    wr(8'hE8, 8'h08);
    wr(8'h10, 8'hA5);
    wr(8'hE8, 8'h10);
    wr(8'h10, 8'h5A);
    rd("ram2", 8'h10, 8'h5A);
    wr(8'hE8, 8'h00);
    wr(8'h10, 8'h00);
    rd("none", 8'h10, 8'hFF);
    wr(8'hE8, 8'h18);
    rd("two", 8'h10, 8'hFF);
    check("conflict", {11'h000, page_conflict_out}, 12'h001);
    wr(8'hE8, 8'h08);
    wr(8'hE8, 8'h10, 1'b1);
    rd("ram1", 8'h10, 8'hA5);
    rd("sel rd", 8'hE8, 8'hFF);
    rd("oth", 8'hC8, 8'h37);
    wr(8'hBF, 8'h3C);
    rd("gram", 8'hBF, 8'h3C);
  endtask
  task automatic t_flow();
    flow('{nmi: 1'b1, default: '0}, 12'hFFC);
    for (int i = 0; i < 4; i++)
      flow('{irq: 1'b1, irq_sel: 2'(i), default: '0}, 12'hFF0 + 12'(2 * i));
    for (int i = 0; i < 6; i++)
      flow('{call: 1'b1, target: 12'h100 + 12'(i), default: '0}, 12'h100 + 12'(i));
    for (int i = 4; i >= 0; i--)
      flow('{ret: 1'b1, default: '0}, 12'h100 + 12'(i));
    flow('{ret: 1'b1, default: '0}, 12'hFF6);
    flow_in = '0;
    // no mapping writes around flow events
    rd("page kept", 8'h10, 8'hA5);
  endtask
  task automatic t_reset();
    reset_in = 1'b1;
    repeat (3) @(negedge clk_in);
    reset_in = 1'b0;
    @(negedge clk_in);
    check("pc rst", pc_out, 12'hFFE);
    rd("base kept", 8'h7F, pf(13'h0FFF));
    rd("sel kept", 8'h10, 8'hA5);
  endtask
  // main sequence
  initial begin
    repeat (3) @(negedge clk_in);
    reset_in = 1'b0;
    @(negedge clk_in);
    t_window();
    t_pages();
    t_flow();
    ext(13'h0A19, 1'b0, pf(13'h0A19));
    ext(13'h0A19, 1'b1, 8'hFF);
    t_reset();
    test_done();
  end
  // watchdog well past the expected run
  initial begin
    #32000;
    bad_count++;
    test_done();
  end
endmodule

// >>> testbench/dswbm_mem_model.sv
/* dswbm_mem_model: program memory, eeprom pages and other space.
   Assumes: strobes come from the mapper on the same clock. */
module dswbm_mem_model (
  input  wire logic        clk_in,
  input  wire logic        prog_rd_in,
  input  wire logic [12:0] prog_addr_in,
  output logic      [7:0]  prog_data_out,
  input  wire logic        nvm_rd_in,
  input  wire logic        nvm_page_in,
  input  wire logic [5:0]  nvm_addr_in,
  output logic      [7:0]  nvm_rdata_out,
  input  wire logic        oth_rd_in,
  input  wire logic [7:0]  oth_addr_in,
  output logic      [7:0]  oth_rdata_out
);
  logic [7:0] junk_r = 8'h00;
  logic [7:0] prog_r = 8'h00;
  logic       pv_r   = 1'b0;
  // rom answers one cycle late; idle lines churn so stale data never matches
  always @(posedge clk_in) begin
    junk_r <= junk_r + 8'h35;
    pv_r <= prog_rd_in;
    prog_r <= prog_addr_in[7:0] ^ {3'b000, prog_addr_in[12:8]};
  end
  assign prog_data_out = pv_r ? prog_r : junk_r;
  // eeprom pages of 64 bytes, page bit on top
  assign nvm_rdata_out = nvm_rd_in ? {1'b1, nvm_page_in, nvm_addr_in} : junk_r;
  assign oth_rdata_out = oth_rd_in ? ~oth_addr_in : junk_r;
endmodule

// >>> verilog/dswbm_mapper.sv
/*
  dswbm_mapper: data space routing, program counter, stack and readout.
  Assumes: one clock; program memory answers a cycle after its strobe.
*/
// What this block does
// - Program counter addressing program space is twelve bits wide.
// - Six twelve-bit return-address levels for calls and interrupts.
// - Reads at 40h to 7Fh go to the program memory window.
// - Window address is base register above low six address bits.
// - One step of the base moves the window 64 bytes.
// - Base at C9h, write only; reads and bit operations meaningless.
// - Base register is not cleared by reset.
// - Base keeps its low six bits, top two ignored.
// - Window reaches 0000h to 0FFFh, bounded by implemented memory.
// - Page select at E8h, write only, no bit operations.
// - Bit 4 RAM page 2, bit 3 RAM page 1, bits 1,0 EEPROM pages.
// - Accesses at 00h to 3Fh go to the selected page, offset as bank zero.
// - Pages span 64 bytes; large variant more pages than small.
// - Page select is not cleared at initialisation.
// - Interrupts and calls leave page select untouched.
// - Sixty bytes of general RAM follow the index and short registers.
// - Vectors: interrupts 0FF0h-0FF7h, NMI 0FFCh, reset 0FFEh-0FFFh.
// - Readout protection blocks external reading of program memory.
`include "dswbm_regs.svh"
module dswbm_mapper
  import dswbm_pkg::*;
#(
  parameter logic                     LARGE_VARIANT = 1'b1,
  parameter logic [`DSWBM_PROG_AW-1:0] PROG_LAST    = `DSWBM_PROG_LAST
) (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     reset_in,
  // core data space port
  input  wire dswbm_req_type            core_req_in,
  output logic                          core_ready_out,
  output logic                          core_ack_out,
  output logic      [7:0]               core_rdata_out,
  // core program flow port
  input  wire dswbm_flow_type           flow_in,
  output logic      [`DSWBM_PC_W-1:0]   pc_out,
  // program memory read port
  output logic                          prog_rd_out,
  output logic      [`DSWBM_PROG_AW-1:0] prog_addr_out,
  input  wire logic [7:0]               prog_data_in,
  // eeprom page port
  output logic                          nvm_rd_out,
  output logic                          nvm_wr_out,
  output logic                          nvm_page_out,
  output logic      [5:0]               nvm_addr_out,
  output logic      [7:0]               nvm_wdata_out,
  input  wire logic [7:0]               nvm_rdata_in,
  // rest of data space port
  output logic                          oth_rd_out,
  output logic                          oth_wr_out,
  output logic      [7:0]               oth_addr_out,
  output logic      [7:0]               oth_wdata_out,
  input  wire logic [7:0]               oth_rdata_in,
  // external readout port
  input  wire logic                     ext_rd_in,
  input  wire logic [`DSWBM_PROG_AW-1:0] ext_addr_in,
  input  wire logic                     protect_in,
  output logic                          ext_ack_out,
  output logic      [7:0]               ext_data_out,
  // status
  output logic                          page_conflict_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [`DSWBM_WIN_BITS-1:0]  win_base_r;
  logic [4:0]                  page_sel_r;
  dswbm_state_type             state_r;
  dswbm_route_type             route_r, dec_route;
  logic                        src_ext_r, ready_r;
  logic [`DSWBM_PC_W-1:0]      pc_r, stack_top;
  logic                        push, pop;
  logic [`DSWBM_PROG_AW-1:0]   win_addr;
  logic [4:0]                  page_used, page_avail;
  logic                        conflict, dec_page_hi;
  logic [7:0]                  gram_off, gram_q, pram_q, cap_data;
  logic                        cap, take_core, take_ext, core_rd, core_wr;
  logic                        ext_rd_s1_r, ext_rd_s2_r, ext_rd_s3_r;
  logic [`DSWBM_PROG_AW-1:0]   ext_addr_s1_r, ext_addr_s2_r;
  logic                        ext_pend_r, ext_blocked;

  // ****************************************************************
  // write-only mapping registers
  // ****************************************************************
  // no reset on purpose: software must load both before use
  always_ff @(posedge clk_in) begin
    if (take_core && core_wr && !core_req_in.bitop) begin
      if (core_req_in.addr == `DSWBM_WIN_BASE_ADDR) begin
        win_base_r <= core_req_in.wdata[`DSWBM_WIN_BITS-1:0];
      end else if (core_req_in.addr == `DSWBM_PAGE_SEL_ADDR) begin
        page_sel_r <= core_req_in.wdata[4:0] & `DSWBM_SEL_USED;
      end
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  // base above the six low address bits; one base step is 64 bytes
  assign win_addr = {1'b0, win_base_r, core_req_in.addr[5:0]};
  assign page_used = page_sel_r & `DSWBM_SEL_USED;
  assign page_avail = LARGE_VARIANT ? `DSWBM_SEL_USED : `DSWBM_SEL_SMALL;
  // several bits set would enable pages in parallel; we select none
  assign conflict = |(page_used & (page_used - 5'h01));
  assign gram_off = core_req_in.addr - `DSWBM_GRAM_LO;
  assign core_rd = core_req_in.rd;
  assign core_wr = core_req_in.wr;

  // region priority follows the data space map
  always_comb begin
    dec_route = RT_OTHER;
    dec_page_hi = 1'b0;
    if (core_req_in.addr <= `DSWBM_PAGE_HI) begin
      if (conflict || !(|(page_used & page_avail))) begin
        dec_route = RT_NONE;
      end else if (page_used[`DSWBM_SEL_RAM2] && page_avail[`DSWBM_SEL_RAM2]) begin
        dec_route = RT_PRAM;
        dec_page_hi = 1'b1;
      end else if (page_used[`DSWBM_SEL_RAM1] && page_avail[`DSWBM_SEL_RAM1]) begin
        dec_route = RT_PRAM;
      end else if (page_used[`DSWBM_SEL_NVM1] && page_avail[`DSWBM_SEL_NVM1]) begin
        dec_route = RT_NVM;
        dec_page_hi = 1'b1;
      end else begin
        dec_route = RT_NVM;
      end
    end else if (core_req_in.addr >= `DSWBM_WIN_LO &&
                 core_req_in.addr <= `DSWBM_WIN_HI) begin
      if (core_wr || win_addr > PROG_LAST || win_addr > `DSWBM_PROG_TOP) begin
        dec_route = RT_NONE;
      end else begin
        dec_route = RT_WINDOW;
      end
    end else if (core_req_in.addr >= `DSWBM_GRAM_LO &&
                 core_req_in.addr <= `DSWBM_GRAM_HI) begin
      dec_route = RT_GRAM;
    end else if (core_req_in.addr == `DSWBM_WIN_BASE_ADDR ||
                 core_req_in.addr == `DSWBM_PAGE_SEL_ADDR) begin
      dec_route = RT_NONE;
    end
  end

  // ****************************************************************
  // local memories
  // ****************************************************************
  // both switchable RAM pages share one array, bit 6 picks the page
  dswbm_mem #(
    .DEPTH (2 * `DSWBM_PAGE_BYTES),
    .AW    (7)
  ) u_page_ram (
    .clk_in    (clk_in),
    .wr_in     (take_core && core_wr && dec_route == RT_PRAM),
    .rd_in     (take_core && core_rd && dec_route == RT_PRAM),
    .addr_in   ({dec_page_hi, core_req_in.addr[5:0]}),
    .wdata_in  (core_req_in.wdata),
    .rdata_out (pram_q)
  );

  // general RAM between the short registers and the ports
  dswbm_mem #(
    .DEPTH (`DSWBM_GRAM_BYTES),
    .AW    (6)
  ) u_gen_ram (
    .clk_in    (clk_in),
    .wr_in     (take_core && core_wr && dec_route == RT_GRAM),
    .rd_in     (take_core && core_rd && dec_route == RT_GRAM),
    .addr_in   (gram_off[5:0]),
    .wdata_in  (core_req_in.wdata),
    .rdata_out (gram_q)
  );

  // ****************************************************************
  // external readout request
  // ****************************************************************
  // pin inputs pass two flops; the third only feeds edge detection
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      {ext_rd_s1_r, ext_rd_s2_r, ext_rd_s3_r} <= 3'b000;
    end else begin
      {ext_rd_s1_r, ext_rd_s2_r, ext_rd_s3_r} <= {ext_rd_in, ext_rd_s1_r, ext_rd_s2_r};
    end
  end

  // address must be stable while the request is held
  always_ff @(posedge clk_in) begin
    ext_addr_s1_r <= ext_addr_in;
    ext_addr_s2_r <= ext_addr_s1_r;
  end

  // a new edge in the cycle of service wins over the clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ext_pend_r <= 1'b0;
    end else if (ext_rd_s2_r && !ext_rd_s3_r) begin
      ext_pend_r <= 1'b1;
    end else if (take_ext) begin
      ext_pend_r <= 1'b0;
    end
  end

  assign ext_blocked = protect_in || ext_addr_s2_r > PROG_LAST;

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  // core has priority; readout only fills idle cycles
  assign take_core = state_r == ST_IDLE && (core_rd || core_wr);
  assign take_ext = state_r == ST_IDLE && !(core_rd || core_wr) && ext_pend_r;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_r <= ST_IDLE;
      route_r <= RT_NONE;
      src_ext_r <= 1'b0;
      ready_r <= 1'b1;
      prog_rd_out <= 1'b0;
      prog_addr_out <= 13'h0000;
      {nvm_rd_out, nvm_wr_out, oth_rd_out, oth_wr_out} <= 4'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take_core) begin
            route_r <= dec_route;
            src_ext_r <= 1'b0;
            ready_r <= 1'b0;
            nvm_rd_out <= core_rd && dec_route == RT_NVM;
            nvm_wr_out <= core_wr && dec_route == RT_NVM;
            oth_rd_out <= core_rd && dec_route == RT_OTHER;
            oth_wr_out <= core_wr && dec_route == RT_OTHER;
            if (core_rd && dec_route == RT_WINDOW) begin
              prog_rd_out <= 1'b1;
              prog_addr_out <= win_addr;
              state_r <= ST_ROM;
            end else begin
              state_r <= ST_MEM;
            end
          end else if (take_ext) begin
            src_ext_r <= 1'b1;
            ready_r <= 1'b0;
            if (ext_blocked) begin
              route_r <= RT_NONE;
              state_r <= ST_MEM;
            end else begin
              route_r <= RT_WINDOW;
              prog_rd_out <= 1'b1;
              prog_addr_out <= ext_addr_s2_r;
              state_r <= ST_ROM;
            end
          end
        end
        ST_MEM: begin
          {nvm_rd_out, nvm_wr_out, oth_rd_out, oth_wr_out} <= 4'h0;
          ready_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        ST_ROM: begin
          prog_rd_out <= 1'b0;
          state_r <= ST_ROMW;
        end
        ST_ROMW: begin
          ready_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // address and data held with the strobes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      {nvm_page_out, nvm_addr_out, nvm_wdata_out} <= 15'h0000;
      {oth_addr_out, oth_wdata_out} <= 16'h0000;
    end else if (take_core) begin
      nvm_page_out <= dec_page_hi;
      nvm_addr_out <= core_req_in.addr[5:0];
      nvm_wdata_out <= core_req_in.wdata;
      oth_addr_out <= core_req_in.addr;
      oth_wdata_out <= core_req_in.wdata;
    end
  end

  // ****************************************************************
  // answers
  // ****************************************************************
  // unselected or write-only places read as the fill value
  always_comb begin
    cap = state_r == ST_MEM || state_r == ST_ROMW;
    cap_data = `DSWBM_FILL;
    if (state_r == ST_ROMW) begin
      cap_data = prog_data_in;
    end else if (route_r == RT_GRAM) begin
      cap_data = gram_q;
    end else if (route_r == RT_PRAM) begin
      cap_data = pram_q;
    end else if (route_r == RT_NVM) begin
      cap_data = nvm_rdata_in;
    end else if (route_r == RT_OTHER) begin
      cap_data = oth_rdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      core_ack_out <= 1'b0;
      core_rdata_out <= 8'h00;
      ext_ack_out <= 1'b0;
      ext_data_out <= 8'h00;
      page_conflict_out <= 1'b0;
    end else begin
      core_ack_out <= cap && !src_ext_r;
      ext_ack_out <= cap && src_ext_r;
      page_conflict_out <= conflict;
      if (cap && !src_ext_r) begin
        core_rdata_out <= cap_data;
      end
      if (cap && src_ext_r) begin
        ext_data_out <= cap_data;
      end
    end
  end

  assign core_ready_out = ready_r;

  // ****************************************************************
  // program counter and return stack
  // ****************************************************************
  // entries push the address the core has already advanced to
  assign push = flow_in.nmi || flow_in.irq || flow_in.call;
  assign pop = !push && flow_in.ret;

  dswbm_stack u_stack (
    .clk_in       (clk_in),
    .reset_in     (reset_in),
    .push_in      (push),
    .pop_in       (pop),
    .push_data_in (pc_r),
    .top_out      (stack_top)
  );

  // mapping registers are not touched by any flow event
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pc_r <= `DSWBM_RESET_VEC;
    end else if (flow_in.nmi) begin
      pc_r <= `DSWBM_NMI_VEC;
    end else if (flow_in.irq) begin
      pc_r <= `DSWBM_IRQ_VEC_BASE + {9'h000, flow_in.irq_sel, 1'b0};
    end else if (pop) begin
      pc_r <= stack_top;
    end else if (flow_in.call || flow_in.jump) begin
      pc_r <= flow_in.target;
    end else if (flow_in.inc) begin
      pc_r <= pc_r + 12'h001;  // wraps within twelve bits
    end
  end

  assign pc_out = pc_r;

endmodule

// >>> verilog/dswbm_mem.sv
/*
  dswbm_mem: small single-port byte memory with registered read data.
  Assumes: one clock; read and write never requested together.
*/
module dswbm_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // clock
  input  wire logic          clk_in,
  // access port
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [7:0]    wdata_in,
  output logic      [7:0]    rdata_out
);

  logic [7:0] mem_r [DEPTH];

  // contents carry no reset, like any RAM cell
  always_ff @(posedge clk_in) begin
    if (wr_in) begin
      mem_r[addr_in] <= wdata_in;
    end
  end

  // read data from a register, one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (rd_in) begin
      rdata_out <= mem_r[addr_in];
    end
  end

endmodule

// >>> verilog/dswbm_stack.sv
/*
  dswbm_stack: six-level return-address stack of 12-bit entries.
  Assumes: push and pop are never pulsed in the same cycle.
*/
`include "dswbm_regs.svh"
module dswbm_stack (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  // stack port
  input  wire logic                   push_in,
  input  wire logic                   pop_in,
  input  wire logic [`DSWBM_PC_W-1:0] push_data_in,
  output logic      [`DSWBM_PC_W-1:0] top_out
);

  logic [`DSWBM_PC_W-1:0] lvl_r [`DSWBM_STACK_DEPTH];

  // shift stack: a seventh push drops the oldest level
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < `DSWBM_STACK_DEPTH; i++) begin
        lvl_r[i] <= `DSWBM_PC_RESET;
      end
    end else if (push_in) begin
      lvl_r[0] <= push_data_in;
      for (int i = 1; i < `DSWBM_STACK_DEPTH; i++) begin
        lvl_r[i] <= lvl_r[i-1];
      end
    end else if (pop_in) begin
      for (int i = 0; i < `DSWBM_STACK_DEPTH - 1; i++) begin
        lvl_r[i] <= lvl_r[i+1];
      end
    end
  end

  assign top_out = lvl_r[0];

endmodule
